// ### inc/safety_fault_status_defines.vh
`ifndef SAFETY_FAULT_STATUS_DEFINES_VH
`define SAFETY_FAULT_STATUS_DEFINES_VH

// Byte addresses of the register words on the bus.
`define ADDR_SELF_TEST_ONE      8'h00
`define ADDR_SELF_TEST_TWO      8'h04
`define ADDR_FAULT_CTRL         8'h08
`define ADDR_FAULT_CTRL_INV     8'h0C
`define ADDR_MONITOR_STATUS     8'h10

// First self-test result word.
`define BIT_MON1_OV_SELFTEST    2
`define BIT_OSC_SELFTEST        1
`define BIT_CRC_SELFTEST        0

// Second self-test result word.
`define BIT_SAFETY_STUCK_LOW    13
`define BIT_SAFETY_STUCK_HIGH   12
`define BIT_POWER_GOOD_OUTPUT_TWO_STUCK_LOW    11
`define BIT_POWER_GOOD_OUTPUT_TWO_STUCK_HIGH   10
`define BIT_POWER_GOOD_OUTPUT_ONE_STUCK_LOW    9
`define BIT_POWER_GOOD_OUTPUT_ONE_STUCK_HIGH   8
`define BIT_LOGIC_RAN           1
`define BIT_LOGIC_PASSED        0

// Fault counter control word and its inverse copy.
`define BIT_TALLY_CLEAR         6
`define TALLY_MSB               5
`define TALLY_LSB               2
`define CEIL_MSB                1
`define CEIL_LSB                0

// Monitor status word: bits 14 down to 0 are latched flags.
`define MON_STATUS_MSB          14
`define BIT_CONV2_ILIM          14
`define BIT_CONV1_ILIM          13
`define BIT_THERMAL_SHUTDOWN    12

// Reset values.
`define RST_CEIL                2'h0
`define RST_CEIL_INV            2'h3
`define RST_CLEAR_INV           1'h1
`define RST_TALLY               4'h0

// Counter maximum for each ceiling code.
`define CEIL_MAX_00             4'h1
`define CEIL_MAX_01             4'h2
`define CEIL_MAX_10             4'h6
`define CEIL_MAX_11             4'hC

`endif

// ### hw/safety_fault_status_regs.v
// How it works
// - First self-test word bit 2: monitor one overvoltage checker found faulty.
// - First self-test word bit 1: oscillator monitoring fault found by analog self-test.
// - First self-test word bit 0: program memory checksum mismatch during analog self-test.
// - Second self-test word bit 13: safety fail output stuck low.
// - Second self-test word bit 12: safety fail output stuck high.
// - Bits 11 and 10: power good two stuck low and stuck high.
// - Bits 9 and 8: power good one stuck low and stuck high.
// - Bit 1 reads one once the logic self-test has run.
// - Bit 0 reads one only when the logic self-test ran and passed.
// - Writing one to control bit 6 clears the tally when inverse word bit 6 is zero; the bit self-clears.
// - Control bits 5 to 2 show the fault tally, 0 to 12.
// - Control bits 1 to 0 pick the tally maximum 1, 2, 6 or 12.
// - A new ceiling applies only when it equals the inverted copy's complement.
// - Inverse word holds bit 6 and bits 1 to 0 as inverted companions.
// - Monitor bits 14 and 13 latch current limit of converter two and one.
// - Monitor bit 12 latches thermal shutdown until cleared.
// - Monitor bits 11 to 8 latch undervoltage of converters 2,1 and monitors 4,3.
// - Every flag, tally and ceiling returns to its reset value on reset.
// - Monitor bits 7 to 0 latch remaining undervoltage and overvoltage faults.
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "safety_fault_status_defines.vh"

module safety_fault_status_regs #(
    parameter AW = 8
) (
    input  wire          clk_i,                // System clock, 10 MHz.
    input  wire          rst_i,                // Synchronous reset, active high.
    input  wire          wb_cyc_i,             // Bus cycle.
    input  wire          wb_stb_i,             // Bus strobe.
    input  wire          wb_we_i,              // Write enable.
    input  wire [AW-1:0] wb_adr_i,             // Byte address.
    input  wire [3:0]    wb_sel_i,             // Byte lane selects.
    input  wire [31:0]   wb_dat_i,             // Write data.
    output reg  [31:0]   wb_dat_o,             // Read data.
    output reg           wb_ack_o,             // Acknowledge.
    input  wire          analog_test_done_i,   // Pulse: analog self-test results valid.
    input  wire [2:0]    analog_test_err_i,    // Monitor one OV, oscillator, checksum.
    input  wire          pin_check_done_i,     // Pulse: pin stuck-at results valid.
    input  wire [5:0]    pin_stuck_i,          // Stuck flags in bit order 13 down to 8.
    input  wire          logic_test_done_i,    // Pulse: logic self-test finished.
    input  wire          logic_test_pass_i,    // Logic self-test passed.
    input  wire          fault_event_i,        // Pulse: one fault to count.
    input  wire [14:0]   monitor_event_i,      // Pulses: monitor faults in bit order.
    output reg  [3:0]    fault_tally_o,        // Current fault tally.
    output reg  [1:0]    fault_tally_ceiling_o, // Applied ceiling code.
    output reg           fault_tally_full_o    // Tally has reached its maximum.
);

    // Stored fields of the register group.
    reg  [2:0]  analog_flags;
    reg  [5:0]  pin_flags;
    reg         logic_selftest_ran;
    reg         logic_selftest_passed;
    reg  [3:0]  fault_tally;
    reg  [1:0]  fault_tally_ceiling;
    reg  [1:0]  inverted_ceiling_copy;
    reg         inverted_clear_copy;
    reg  [1:0]  current_limit_flags;
    reg         thermal_shutdown_latch;
    reg  [5:0]  undervoltage_flags;
    reg  [5:0]  overvoltage_flags;

    // Next values, all built combinationally.
    reg  [3:0]  next_tally;
    reg  [1:0]  next_ceiling;
    reg         next_full;
    reg  [14:0] next_monitor_flags;
    reg  [31:0] next_rdata;

    wire        req;
    wire        rd_req;
    wire        wr_req;
    wire        wr_low_lane;
    wire        hit_ctrl;
    wire        hit_inv;
    wire        hit_mon;
    wire        wr_ctrl;
    wire        wr_inv;
    wire        wr_mon;
    wire [1:0]  wr_ceiling;
    wire        wr_clear;
    wire        clear_ok;
    wire        ceil_ok;
    wire [14:0] mon_lane_mask;
    wire [14:0] mon_clear;
    wire [14:0] monitor_flags;
    wire [15:0] word_self_test_one;
    wire [15:0] word_self_test_two;
    wire [15:0] word_fault_ctrl;
    wire [15:0] word_fault_ctrl_inv;
    wire [15:0] word_monitor;

    // Maximum tally value for a ceiling code.
    function [3:0] ceil_max;
        input [1:0] code;
        begin
            case (code)
                2'h0:    ceil_max = `CEIL_MAX_00;
                2'h1:    ceil_max = `CEIL_MAX_01;
                2'h2:    ceil_max = `CEIL_MAX_10;
                2'h3:    ceil_max = `CEIL_MAX_11;
                default: ceil_max = `CEIL_MAX_00;
            endcase
        end
    endfunction

    // One-cycle answer; the ack drops in the cycle after it is given.
    assign req         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_req      = req & ~wb_we_i;
    assign wr_req      = req & wb_we_i;
    assign wr_low_lane = wr_req & wb_sel_i[0];

    assign hit_ctrl = (wb_adr_i == `ADDR_FAULT_CTRL);
    assign hit_inv  = (wb_adr_i == `ADDR_FAULT_CTRL_INV);
    assign hit_mon  = (wb_adr_i == `ADDR_MONITOR_STATUS);

    assign wr_ctrl = wr_low_lane & hit_ctrl;
    assign wr_inv  = wr_low_lane & hit_inv;
    assign wr_mon  = wr_req & hit_mon;

    assign wr_ceiling = wb_dat_i[`CEIL_MSB:`CEIL_LSB];
    assign wr_clear   = wb_dat_i[`BIT_TALLY_CLEAR];

    // Commands take effect only against an inverted companion copy.
    assign clear_ok = wr_ctrl & wr_clear & ~inverted_clear_copy;
    assign ceil_ok  = wr_ctrl & (wr_ceiling == ~inverted_ceiling_copy);

    // Write one to clear a latched monitor flag, lane by lane.
    assign mon_lane_mask = {{7{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign mon_clear     = wr_mon ? (wb_dat_i[14:0] & mon_lane_mask) : 15'h0000;

    assign monitor_flags = {current_limit_flags, thermal_shutdown_latch,
                            undervoltage_flags, overvoltage_flags};

    // Read words; the clear bit always reads back as zero since it self-clears.
    assign word_self_test_one  = {13'h0000, analog_flags};
    assign word_self_test_two  = {2'h0, pin_flags, 6'h00, logic_selftest_ran,
                                  logic_selftest_passed};
    assign word_fault_ctrl     = {9'h000, 1'h0, fault_tally, fault_tally_ceiling};
    assign word_fault_ctrl_inv = {9'h000, inverted_clear_copy, 4'h0, inverted_ceiling_copy};
    assign word_monitor        = {1'h0, monitor_flags};

    always @*
    begin
        next_rdata = 32'h00000000;
        case (wb_adr_i)
            `ADDR_SELF_TEST_ONE:
            begin
                next_rdata[15:0] = word_self_test_one;
            end
            `ADDR_SELF_TEST_TWO:
            begin
                next_rdata[15:0] = word_self_test_two;
            end
            `ADDR_FAULT_CTRL:
            begin
                next_rdata[15:0] = word_fault_ctrl;
            end
            `ADDR_FAULT_CTRL_INV:
            begin
                next_rdata[15:0] = word_fault_ctrl_inv;
            end
            `ADDR_MONITOR_STATUS:
            begin
                next_rdata[15:0] = word_monitor;
            end
            default:
            begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // Tally update: a clear wins, but a fault in the same cycle is still counted.
    always @*
    begin
        next_tally = clear_ok ? `RST_TALLY : fault_tally;
        if (fault_event_i && (next_tally < ceil_max(fault_tally_ceiling)))
        begin
            next_tally = next_tally + 4'h1;
        end
    end

    always @*
    begin
        next_ceiling = ceil_ok ? wr_ceiling : fault_tally_ceiling;
        next_full    = (next_tally >= ceil_max(next_ceiling));
    end

    // New events win over a clear in the same cycle.
    always @*
    begin
        next_monitor_flags = (monitor_flags & ~mon_clear) | monitor_event_i;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            analog_flags <= 3'h0;
        end
        else if (analog_test_done_i)
        begin
            analog_flags <= analog_test_err_i;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_flags <= 6'h00;
        end
        else if (pin_check_done_i)
        begin
            pin_flags <= pin_stuck_i;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            logic_selftest_ran    <= 1'h0;
            logic_selftest_passed <= 1'h0;
        end
        else if (logic_test_done_i)
        begin
            logic_selftest_ran    <= 1'h1;
            logic_selftest_passed <= logic_test_pass_i;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_tally <= `RST_TALLY;
        end
        else
        begin
            fault_tally <= next_tally;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_tally_ceiling <= `RST_CEIL;
        end
        else
        begin
            fault_tally_ceiling <= next_ceiling;
        end
    end

    // The inverse word resets to the complement of the control word.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            inverted_ceiling_copy <= `RST_CEIL_INV;
            inverted_clear_copy   <= `RST_CLEAR_INV;
        end
        else if (wr_inv)
        begin
            inverted_ceiling_copy <= wr_ceiling;
            inverted_clear_copy   <= wr_clear;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            current_limit_flags <= 2'h0;
        end
        else
        begin
            current_limit_flags <= next_monitor_flags[14:13];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            thermal_shutdown_latch <= 1'h0;
        end
        else
        begin
            thermal_shutdown_latch <= next_monitor_flags[12];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            undervoltage_flags <= 6'h00;
        end
        else
        begin
            undervoltage_flags <= next_monitor_flags[11:6];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overvoltage_flags <= 6'h00;
        end
        else
        begin
            overvoltage_flags <= next_monitor_flags[5:0];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'h0;
        end
        else
        begin
            wb_ack_o <= req;
        end
    end

    // Read data is zero outside the acknowledge cycle.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_dat_o <= rd_req ? next_rdata : 32'h00000000;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_tally_o <= `RST_TALLY;
        end
        else
        begin
            fault_tally_o <= next_tally;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_tally_ceiling_o <= `RST_CEIL;
        end
        else
        begin
            fault_tally_ceiling_o <= next_ceiling;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_tally_full_o <= 1'h0;
        end
        else
        begin
            fault_tally_full_o <= next_full;
        end
    end

endmodule

// ### dv/safety_fault_status_regs_assertions.sv
`timescale 1ns/1ps
module safety_fault_status_checker #(
    parameter AW = 8
) (
    input wire          clk_i,                 // Clock.
    input wire          rst_i,                 // Reset.
    input wire          wb_cyc_i,              // Bus cycle.
    input wire          wb_stb_i,              // Bus strobe.
    input wire          wb_we_i,               // Write enable.
    input wire [AW-1:0] wb_adr_i,              // Address.
    input wire [31:0]   wb_dat_o,              // Read data.
    input wire          wb_ack_o,              // Acknowledge.
    input wire          fault_event_i,         // Fault pulse.
    input wire [3:0]    fault_tally_o,         // Tally.
    input wire [1:0]    fault_tally_ceiling_o, // Ceiling code.
    input wire          fault_tally_full_o     // Tally full.
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire      wr = wb_cyc_i && wb_stb_i && wb_we_i;
    reg [3:0] lim;
    always @*
    begin
        case (fault_tally_ceiling_o)
            2'h0: lim = 4'h1;
            2'h1: lim = 4'h2;
            2'h2: lim = 4'h6;
            default: lim = 4'hC;
        endcase
    end
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_upper_half_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_tally_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 'h08
        |-> wb_dat_o[6:2] == {1'b0, $past(fault_tally_o)}) else $error("tally readback wrong");
    a_tally_steps: assert property (fault_event_i && !fault_tally_full_o && !wr
        |=> fault_tally_o == $past(fault_tally_o) + 4'h1) else $error("tally did not step");
    a_tally_holds: assert property ((!fault_event_i || fault_tally_full_o) && !wr
        |=> $stable(fault_tally_o)) else $error("tally moved without cause");
    a_full_flag: assert property (fault_tally_full_o == (fault_tally_o >= lim))
        else $error("full flag disagrees with ceiling");
    a_ceiling_by_write: assert property (!wr |=> $stable(fault_tally_ceiling_o))
        else $error("ceiling changed without write");
    a_reset_state: assert property ($past(rst_i) |-> fault_tally_o == 4'h0
        && fault_tally_ceiling_o == 2'h0 && !fault_tally_full_o) else $error("bad reset state");
    cover property (fault_tally_full_o && fault_event_i);
    cover property (wr && wb_adr_i == 'h08);
    cover property (wb_ack_o && !wb_we_i);
endmodule

// ### dv/test_safety_fault_status_regs.sv
`timescale 1ns/1ps
module test_safety_fault_status_regs;
    reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg analog_test_done_i = 0, pin_check_done_i = 0, logic_test_done_i = 0;
    reg logic_test_pass_i = 0, fault_event_i = 0;
    reg [7:0] wb_adr_i = 0;
    reg [3:0] wb_sel_i = 0;
    reg [31:0] wb_dat_i = 0, q;
    reg [2:0] analog_test_err_i = 0;
    reg [5:0] pin_stuck_i = 0;
    reg [14:0] monitor_event_i = 0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, fault_tally_full_o;
    wire [3:0] fault_tally_o;
    wire [1:0] fault_tally_ceiling_o;
    int n_mismatch = 0, comparisons = 0, c;
    safety_fault_status_regs u_safety_fault_status_regs (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_test_done_i(analog_test_done_i),
        .analog_test_err_i(analog_test_err_i), .pin_check_done_i(pin_check_done_i),
        .pin_stuck_i(pin_stuck_i), .logic_test_done_i(logic_test_done_i),
        .logic_test_pass_i(logic_test_pass_i), .fault_event_i(fault_event_i),
        .monitor_event_i(monitor_event_i), .fault_tally_o(fault_tally_o),
        .fault_tally_ceiling_o(fault_tally_ceiling_o),
        .fault_tally_full_o(fault_tally_full_o));
    initial forever #50 clk_i = ~clk_i;
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle; the request stands until the edge that samples ack.
    task bus(input [7:0] a, input w, input [31:0] d);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, 4'hF};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        if (wb_ack_o !== 1'b1)
        begin
            n_mismatch++;
            end_sim;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        bus(a, 0, 0);
        chk($sformatf("reg %h", a), q, e);
    endtask
    task selftest(input [2:0] e, input [5:0] s, input p);
        @(posedge clk_i);
        {analog_test_err_i, pin_stuck_i, logic_test_pass_i} <= {e, s, p};
        {analog_test_done_i, pin_check_done_i, logic_test_done_i} <= 3'h7;
        @(posedge clk_i);
        {analog_test_done_i, pin_check_done_i, logic_test_done_i} <= 3'h0;
    endtask
    function [3:0] cmax(input [1:0] k);
        cmax = k == 0 ? 4'h1 : k == 1 ? 4'h2 : k == 2 ? 4'h6 : 4'hC;
    endfunction
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        rd(8'h00, 0);
        rd(8'h04, 0);
        rd(8'h08, 0);
        rd(8'h0C, 32'h43);
        rd(8'h10, 0);
        rd(8'h14, 0);
        $display("test reset_state done");
        selftest(3'h5, 6'h29, 0);
        rd(8'h00, 32'h5);
        rd(8'h04, 32'h2902);
        selftest(3'h2, 6'h16, 1);
        rd(8'h00, 32'h2);
        rd(8'h04, 32'h1603);
        bus(8'h00, 1, 32'hFFFF);
        rd(8'h00, 32'h2);
        $display("test self_test done");
        for (c = 0; c < 4; c++)
        begin
            bus(8'h0C, 1, ~c & 3);
            bus(8'h08, 1, 32'h40 | c);
            chk("ceiling", fault_tally_ceiling_o, c);
            rd(8'h08, c);
            @(posedge clk_i);
            fault_event_i <= 1;
            repeat (13) @(posedge clk_i);
            fault_event_i <= 0;
            rd(8'h08, cmax(c) << 2 | c);
            chk("full", fault_tally_full_o, 1);
        end
        bus(8'h08, 1, 32'h01);
        chk("ceiling", fault_tally_ceiling_o, 3);
        chk("tally", fault_tally_o, 12);
        bus(8'h0C, 1, 32'h40);
        bus(8'h08, 1, 32'h43);
        chk("tally", fault_tally_o, 12);
        $display("test fault_tally done");
        @(posedge clk_i);
        monitor_event_i <= 15'h7FFF;
        @(posedge clk_i);
        monitor_event_i <= 0;
        rd(8'h10, 32'h7FFF);
        bus(8'h10, 1, 32'h7000);
        rd(8'h10, 32'h0FFF);
        $display("test monitor done");
        @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        chk("tally", {fault_tally_full_o, fault_tally_ceiling_o, fault_tally_o}, 0);
        rd(8'h04, 0);
        rd(8'h10, 0);
        $display("test mid_reset done");
        end_sim;
    end
endmodule
bind safety_fault_status_regs safety_fault_status_checker #(.AW(AW)) u_chk (.*);
